// ---- bench/scp_i2c_master.sv ----
// Behavioural I2C bus master; clock stands high between frames
module scp_i2c_master
#(
  parameter int Q = 80
)
(
  // Bus wires
  output logic scl,
  output logic sda_rel,
  input wire logic sda
);
  timeunit 1ns;
  timeprecision 100ps;

  initial
  begin
    scl = 1'b1;
    sda_rel = 1'b1;
  end

  task automatic bit_cyc(input logic b, output logic r);
    sda_rel = b;
    #Q scl = 1'b1;
    #Q r = sda;
    #Q scl = 1'b0;
    #Q;
  endtask : bit_cyc

  task automatic start();
    sda_rel = 1'b1;
    #Q scl = 1'b1;
    #Q sda_rel = 1'b0;
    #Q scl = 1'b0;
    #Q;
  endtask : start

  task automatic stop();
    sda_rel = 1'b0;
    #Q scl = 1'b1;
    #Q sda_rel = 1'b1;
    #Q;
  endtask : stop

  // Short clock pulse, must be filtered out by the slave
  task automatic glitch();
    scl = 1'b1;
    #30 scl = 1'b0;
    #Q;
  endtask : glitch

  task automatic xfer(input logic [7:0] d, input int n, input logic mack,
                      output logic [7:0] q, output logic ack);
    q = 8'h00;
    for (int i = 7; i > 7 - n; i--)
      bit_cyc(d[i], q[i]);
    ack = 1'b1;
    if (n == 8)
      bit_cyc(mack, ack);
  endtask : xfer
endmodule : scp_i2c_master

// ---- bench/scp_slave_properties.sv ----
// Concurrent checks on the serial control port slave ports
module scp_slave_properties
  import scp_pkg::*;
(
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  // Serial pins
  input wire logic ser_clk,
  input wire logic ser_data_in,
  input wire logic ser_data_out,
  input wire logic ser_data_oe,
  input wire logic ser_cs_n,
  // Straps and control
  input wire logic strap_pin_0,
  input wire logic strap_pin_1,
  input wire logic strap_pin_2,
  input wire logic lsb_first,
  input wire logic i2c_mode,
  input wire logic spi_wr_ovf,
  // Register side
  input wire logic rd_req,
  input wire logic [ADDR_W-1:0] rd_addr,
  input wire logic [DATA_W-1:0] rd_data,
  input wire logic wr_valid,
  input wire logic wr_ready,
  input wire logic [ADDR_W-1:0] wr_addr,
  input wire logic [DATA_W-1:0] wr_data
);
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (rst);

  strap_mode_a: assert property ($fell(rst) &&
    {strap_pin_2, strap_pin_1, strap_pin_0} != 3'h0 |-> ##[1:6] i2c_mode)
    else $error("i2c mode not taken from straps");
  mode_hold_a: assert property (i2c_mode |=> i2c_mode)
    else $error("i2c mode dropped");
  pull_only_a: assert property (i2c_mode |-> !ser_data_out)
    else $error("data line driven high in i2c mode");
  sda_change_a: assert property (i2c_mode && $changed(ser_data_oe)
    |-> !ser_clk)
    else $error("data line changed while clock high");
  rd_pulse_a: assert property (rd_req |=> !rd_req [*8])
    else $error("register reads too close");
  rd_addr_hold_a: assert property ($changed(rd_addr) |-> rd_req)
    else $error("read address moved without request");
  wr_hold_a: assert property (wr_valid && !wr_ready |=>
    wr_valid && $stable({wr_addr, wr_data}))
    else $error("write entry changed while stalled");
  wr_drop_a: assert property ($fell(wr_valid) |-> $past(wr_ready))
    else $error("write entry lost without pop");

  cover property (rd_req);
  cover property (wr_valid && wr_ready);
  cover property ($rose(ser_data_oe));
endmodule : scp_slave_properties

bind scp_slave scp_slave_properties i_props (.*);

// ---- bench/test_serial_control_port_slave.sv ----
// Self-checking bench for the serial control port slave, I2C and SPI modes
module test_serial_control_port_slave
  import scp_pkg::*;
();
  timeunit 1ns;
  timeprecision 100ps;

  localparam logic [6:0] SADDR = {4'h9, 3'h5};
  localparam int DEPTH = FIFO_DEPTH;
  logic cs_n = 1'b1;
  logic lsb = 1'b0;
  logic [2:0] straps = 3'h5;
  logic clk_sys = 1'b0;
  logic rst = 1'b1;
  logic wr_ready = 1'b0;
  logic [7:0] rd_data = 8'h00;
  logic scl, sda_rel, ser_data_out, ser_data_oe, i2c_mode, spi_wr_ovf;
  logic rd_req, wr_valid;
  logic [15:0] rd_addr, wr_addr;
  logic [7:0] wr_data;
  wire logic sda;
  int err_count = 0;
  int samples_checked = 0;
  logic [31:0] seed = 32'h0000_0051;

  // Pull-up wire: slave only ever pulls low
  assign sda = sda_rel & ~ser_data_oe;

  scp_i2c_master i_mst (.scl(scl), .sda_rel(sda_rel), .sda(sda));

  scp_slave i_dut (
    .clk_sys(clk_sys), .rst(rst), .ser_clk(scl), .ser_data_in(sda),
    .ser_data_out(ser_data_out), .ser_data_oe(ser_data_oe),
    .ser_cs_n(cs_n), .strap_pin_0(straps[0]), .strap_pin_1(straps[1]),
    .strap_pin_2(straps[2]), .lsb_first(lsb), .i2c_mode(i2c_mode),
    .spi_wr_ovf(spi_wr_ovf), .rd_req(rd_req), .rd_addr(rd_addr),
    .rd_data(rd_data), .wr_valid(wr_valid), .wr_ready(wr_ready),
    .wr_addr(wr_addr), .wr_data(wr_data));

  initial
  begin
    forever #2.5 clk_sys = ~clk_sys;
  end

  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : rnd

  function automatic logic [7:0] reg_val(input logic [15:0] a);
    return a[7:0] ^ a[15:8] ^ 8'h5A;
  endfunction : reg_val

  // Register file answers on the falling clock edge while the request is high
  always @(negedge clk_sys)
    if (rd_req === 1'b1)
      rd_data <= reg_val(rd_addr);

  task automatic chk(input string what, input logic [31:0] exp,
                     input logic [31:0] got);
    samples_checked++;
    if (got !== exp)
    begin
      err_count++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  task automatic finish_test();
    $display("Checks %0d mismatches %0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : finish_test

  task automatic wbyte(input logic [7:0] d, input logic ack);
    logic [7:0] q;
    logic k;
    i_mst.xfer(d, 8, 1'b1, q, k);
    chk("ack", ack, k);
  endtask : wbyte

  task automatic addr_phase(input logic [15:0] a);
    i_mst.start();
    wbyte({SADDR, 1'b0}, 1'b0);
    wbyte(a[15:8], 1'b0);
    i_mst.glitch();
    wbyte(a[7:0], 1'b0);
  endtask : addr_phase

  task automatic rd_run(input logic [15:0] a, input int n);
    logic [7:0] q;
    logic k;
    i_mst.start();
    wbyte({SADDR, 1'b1}, 1'b0);
    for (int i = 0; i < n; i++)
    begin
      i_mst.xfer(8'hFF, 8, i == n - 1, q, k);
      chk("rd byte", reg_val(a + 16'(i)), q);
    end
    i_mst.stop();
    chk("released", 1'b0, ser_data_oe);
  endtask : rd_run

  initial
  begin : main
    logic [7:0] d[$];
    logic [7:0] q;
    logic k;
    logic [15:0] a;
    int n;
    logic [31:0] w;
    repeat (3) @(posedge clk_sys);
    @(negedge clk_sys) rst = 1'b0;
    repeat (10) @(negedge clk_sys);
    chk("i2c_mode", 1'b1, i2c_mode);
    // Fill the buffer while the register side stalls
    a = 16'(rnd());
    addr_phase(a);
    for (int i = 0; i <= DEPTH; i++)
    begin
      d.push_back(8'(rnd()));
      wbyte(d[i], i == DEPTH);
    end
    i_mst.stop();
    n = 0;
    while (n < DEPTH)
    begin
      @(negedge clk_sys);
      chk("entry", {1'b1, a + 16'(n), d[n]},
          {wr_valid, wr_addr, wr_data});
      wr_ready = rnd() & 32'h1;
      if (wr_ready)
        n++;
    end
    @(negedge clk_sys) wr_ready = 1'b0;
    chk("empty", 1'b0, wr_valid);
    // Another slave address gets no answer
    i_mst.start();
    wbyte({SADDR ^ 7'h01, 1'b0}, 1'b1);
    wbyte(8'hA5, 1'b1);
    i_mst.stop();
    chk("ignored", 1'b0, wr_valid);
    // Pointer load only, then read from it
    a = 16'(rnd());
    addr_phase(a);
    i_mst.stop();
    chk("no write", 1'b0, wr_valid);
    rd_run(a, 3);
    // Random read with repeated start
    a = 16'(rnd());
    addr_phase(a);
    rd_run(a, 2);
    // Partial byte cut by stop is dropped
    a = 16'(rnd());
    addr_phase(a);
    i_mst.xfer(8'(rnd()), 4, 1'b1, q, k);
    i_mst.stop();
    repeat (20) @(negedge clk_sys);
    chk("partial", 1'b0, wr_valid);
    rd_run(a, 1);
    // SPI after a second reset: two-byte writes in both bit orders
    @(negedge clk_sys) straps = 3'h0;
    rst = 1'b1;
    repeat (3) @(negedge clk_sys);
    rst = 1'b0;
    repeat (10) @(negedge clk_sys);
    chk("spi mode", 1'b0, i2c_mode);
    for (int m = 0; m < 2; m++)
    begin
      w = {3'h1, 13'(rnd()), 16'(rnd())};
      lsb = m[0];
      // Park the clock low while the port is still deselected
      i_mst.glitch();
      @(negedge clk_sys) cs_n = 1'b0;
      for (int j = 0; j < 32; j++)
        i_mst.bit_cyc(w[m ? (j < 16 ? j + 16 : j < 24 ? j - 8 : j - 24)
                        : 31 - j], k);
      @(negedge clk_sys) cs_n = 1'b1;
      for (int i = 0; i < 2; i++)
      begin
        @(negedge clk_sys) wr_ready = 1'b1;
        a = {3'h0, m ? w[28:16] + 13'(i) : w[28:16] - 13'(i)};
        chk("spi entry", {1'b1, a, w[15-8*i-:8]},
            {wr_valid, wr_addr, wr_data});
      end
      @(negedge clk_sys) wr_ready = 1'b0;
      chk("spi count", 1'b0, wr_valid);
    end
    finish_test();
  end

  // Run needs about 190 us of bus time
  initial
  begin
    #400000;
    err_count++;
    finish_test();
  end
endmodule : test_serial_control_port_slave

// ---- include/scp_pkg.sv ----
// Shared constants and types for the serial control port slave
package scp_pkg;

  // ****************************************
  // Timing
  // ****************************************
  localparam int CLK_PERIOD_PS = 5000;
  localparam int GLITCH_NS = 50;
  // Least time, rounded up to whole cycles
  localparam int GLITCH_CYC = (GLITCH_NS * 1000 + CLK_PERIOD_PS - 1)
                              / CLK_PERIOD_PS;
  localparam logic [1:0] STRAP_WAIT_CYC = 2'h3;

  // ****************************************
  // Link formats
  // ****************************************
  localparam int INST_BITS = 16;
  localparam int BYTE_BITS = 8;
  localparam logic [4:0] INST_LAST_BIT = 5'(INST_BITS - 1);
  localparam logic [4:0] BYTE_LAST_BIT = 5'(BYTE_BITS - 1);
  localparam logic [4:0] BYTE_DONE = 5'(BYTE_BITS);
  localparam int INST_RW_POS = 15;
  localparam int INST_CNT_POS = 13;
  localparam int REG_ADDR_TOP_BIT = 12;
  localparam logic [1:0] BC_STREAM = 2'h3;
  localparam logic [3:0] I2C_ADDR_TOP = 4'h9;
  localparam logic I2C_DIR_READ = 1'b1;
  localparam logic [1:0] PH_SLAVE = 2'h0;
  localparam logic [1:0] PH_ADDR_HI = 2'h1;
  localparam logic [1:0] PH_ADDR_LO = 2'h2;
  localparam logic [1:0] PH_DATA = 2'h3;

  // ****************************************
  // Reset values and sizes
  // ****************************************
  localparam logic [15:0] PTR_RST = 16'h0000;
  localparam int FIFO_DEPTH = 32;
  localparam int ADDR_W = 16;
  localparam int DATA_W = 8;
  localparam int ENTRY_W = ADDR_W + DATA_W;

  typedef enum logic [3:0] {
    ST_IDLE,
    ST_SPI_INST,
    ST_SPI_WR,
    ST_SPI_RD,
    ST_SPI_DONE,
    ST_I2C_RX,
    ST_I2C_ACK,
    ST_I2C_TX,
    ST_I2C_MACK,
    ST_I2C_IGN
  } scp_state_t;

endpackage : scp_pkg

// ---- logic/scp_fifo.sv ----
// Synchronous FIFO with valid/ready on both sides
module scp_fifo
#(
  parameter int WIDTH = 24,
  parameter int DEPTH = 32
)
(
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  // Fill side
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  // Drain side
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);

  localparam int AW = $clog2(DEPTH);
  localparam logic [AW:0] FULL = (AW + 1)'(DEPTH);
  localparam logic [AW-1:0] LAST = AW'(DEPTH - 1);

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [AW-1:0] wp;
    logic [AW-1:0] rp;
    logic [AW:0] count;
  } scp_fifo_st_t;

  scp_fifo_st_t st_ff;
  scp_fifo_st_t nxt_st;
  logic push;
  logic pop;

  assign in_ready = (st_ff.count != FULL);
  assign out_valid = (st_ff.count != '0);
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;

  always_comb
  begin
    nxt_st = st_ff;
    if (push)
    begin
      nxt_st.mem[st_ff.wp] = in_data;
      nxt_st.wp = (st_ff.wp == LAST) ? '0 : st_ff.wp + 1'b1;
    end
    if (pop)
    begin
      nxt_st.rp = (st_ff.rp == LAST) ? '0 : st_ff.rp + 1'b1;
    end
    nxt_st.count = st_ff.count + (push ? 1'b1 : 1'b0)
                   - (pop ? 1'b1 : 1'b0);
  end

  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      st_ff <= '0;
    end
    else
    begin
      st_ff <= nxt_st;
    end
  end

  assign out_data = st_ff.mem[st_ff.rp];

endmodule : scp_fifo

// ---- logic/scp_filt.sv ----
// Pin synchroniser with per-line glitch filter
module scp_filt
  import scp_pkg::*;
#(
  parameter int W = 6,
  parameter int CNT = GLITCH_CYC
)
(
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  // Pins
  input wire logic [W-1:0] pin,
  // Synchronised and filtered levels
  output logic [W-1:0] raw,
  output logic [W-1:0] filt
);

  localparam int CW = $clog2(CNT + 1);
  localparam logic [CW-1:0] CNT_LAST = CW'(CNT - 1);

  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
    logic [W-1:0] filt;
    logic [W-1:0][CW-1:0] cnt;
  } scp_filt_st_t;

  scp_filt_st_t st_ff;
  scp_filt_st_t nxt_st;

  always_comb
  begin
    nxt_st = st_ff;
    nxt_st.s1 = pin;
    nxt_st.s2 = st_ff.s1;
    // A level must differ for CNT cycles running before it is taken
    for (int i = 0; i < W; i++)
    begin
      if (st_ff.s2[i] == st_ff.filt[i])
      begin
        nxt_st.cnt[i] = '0;
      end
      else if (st_ff.cnt[i] == CNT_LAST)
      begin
        nxt_st.filt[i] = st_ff.s2[i];
        nxt_st.cnt[i] = '0;
      end
      else
      begin
        nxt_st.cnt[i] = st_ff.cnt[i] + 1'b1;
      end
    end
  end

  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      st_ff <= '{s1: '1, s2: '1, filt: '1, cnt: '0};
    end
    else
    begin
      st_ff <= nxt_st;
    end
  end

  assign raw = st_ff.s2;
  assign filt = st_ff.filt;

endmodule : scp_filt

// ---- logic/scp_slave.sv ----
// Serial control port slave: SPI and I2C front end to a byte register space
//
// Overview of operation
// - MSB-first SPI: address decrements after each payload byte toward 0000.
// - LSB-first bit set: bits travel LSB first, address increments.
// - Multibyte accesses never skip reserved or unmapped addresses.
// - SPI instruction: read/write flag, two count bits, 13 address bits.
// - Count bits give one, two, three bytes, or endless streaming.
// - SPI write bits taken on rising clock, read bits driven on falling.
// - I2C clock and data ignore pulses shorter than 50 ns.
// - I2C runs at 100 kHz and at 400 kHz.
// - I2C slave only; the master makes every clock pulse.
// - Slave address is 1001 followed by the three strap levels.
// - Acknowledge only a matching slave address, else idle till next start.
// - Transmitter changes data only while clock is low.
// - Start and stop are data edges while the clock is high.
// - Bytes are eight bits MSB first plus a ninth acknowledge bit.
// - Write: two address bytes high first, then data to consecutive registers.
// - Any number of data bytes per transfer, either direction, until a full write FIFO refuses a byte.
// - Master's not-acknowledge ends a read; device returns to idle.
// - Start or stop accepted anytime; partial bytes are dropped.
// - Write with only address bytes just loads the pointer.
// - Read without address phase starts at the current pointer.
module scp_slave
  import scp_pkg::*;
#(
  parameter int DEPTH = FIFO_DEPTH
)
(
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  // Serial pins: clock, shared data line, chip select
  input wire logic ser_clk,
  input wire logic ser_data_in,
  output logic ser_data_out,
  output logic ser_data_oe,
  input wire logic ser_cs_n,
  // Power-up straps
  input wire logic strap_pin_0,
  input wire logic strap_pin_1,
  input wire logic strap_pin_2,
  // Control and status
  input wire logic lsb_first,
  output logic i2c_mode,
  output logic spi_wr_ovf,
  // Register read port
  output logic rd_req,
  output logic [ADDR_W-1:0] rd_addr,
  input wire logic [DATA_W-1:0] rd_data,
  // Register write stream
  output logic wr_valid,
  input wire logic wr_ready,
  output logic [ADDR_W-1:0] wr_addr,
  output logic [DATA_W-1:0] wr_data
);

  // ****************************************
  // State
  // ****************************************
  typedef struct packed {
    scp_state_t state;
    logic [1:0] strap_wait;
    logic strap_done;
    logic [2:0] strap;
    logic i2c;
    logic clk_d;
    logic dat_d;
    logic [15:0] sh;
    logic [4:0] bits;
    logic [15:0] ptr;
    logic [7:0] addr_hi;
    logic [1:0] phase;
    logic rd_dir;
    logic mack_ok;
    logic [7:0] tx;
    logic [1:0] cap;
    logic [12:0] saddr;
    logic [1:0] left;
    logic stream;
    logic lsb;
    logic rd_req;
    logic [15:0] rd_addr;
    logic push;
    logic [23:0] push_data;
    logic ovf;
    logic sd_out;
    logic sd_oe;
  } scp_st_t;

  scp_st_t st_ff;
  scp_st_t nxt_st;

  // ****************************************
  // Helpers
  // ****************************************
  function automatic logic [12:0] scp_step(input logic [12:0] a,
                                           input logic lsb);
    // Wraps across 1FFF/0000 in either direction, no address skipped
    scp_step = lsb ? a + 1'b1 : a - 1'b1;
  endfunction : scp_step

  function automatic logic [7:0] scp_shin(input logic [7:0] b,
                                          input logic d,
                                          input logic lsb);
    scp_shin = lsb ? {d, b[7:1]} : {b[6:0], d};
  endfunction : scp_shin

  // ****************************************
  // Pin conditioning
  // ****************************************
  logic [5:0] pin_raw;
  logic [5:0] pin_filt;

  scp_filt #(.W(6), .CNT(GLITCH_CYC)) u_filt (
    .clk_sys(clk_sys),
    .rst(rst),
    .pin({strap_pin_2, strap_pin_1, strap_pin_0,
          ser_cs_n, ser_data_in, ser_clk}),
    .raw(pin_raw),
    .filt(pin_filt)
  );

  // I2C sees only filtered lines; SPI is too fast for the filter delay
  logic clk_now;
  logic dat_now;
  logic cs_n_now;
  logic clk_rise;
  logic clk_fall;
  logic i2c_start;
  logic i2c_stop;

  assign clk_now = st_ff.i2c ? pin_filt[0] : pin_raw[0];
  assign dat_now = st_ff.i2c ? pin_filt[1] : pin_raw[1];
  assign cs_n_now = pin_raw[2];
  assign clk_rise = clk_now && !st_ff.clk_d;
  assign clk_fall = !clk_now && st_ff.clk_d;
  // Data edges while clock stays high mark start and stop
  assign i2c_start = clk_now && st_ff.clk_d && st_ff.dat_d && !dat_now;
  assign i2c_stop = clk_now && st_ff.clk_d && !st_ff.dat_d && dat_now;

  // ****************************************
  // Write FIFO
  // ****************************************
  logic fifo_in_ready;
  logic [ENTRY_W-1:0] fifo_out;

  scp_fifo #(.WIDTH(ENTRY_W), .DEPTH(DEPTH)) u_fifo (
    .clk_sys(clk_sys),
    .rst(rst),
    .in_valid(st_ff.push),
    .in_ready(fifo_in_ready),
    .in_data(st_ff.push_data),
    .out_valid(wr_valid),
    .out_ready(wr_ready),
    .out_data(fifo_out)
  );

  // ****************************************
  // Protocol engine
  // ****************************************
  logic [15:0] inst_w;
  logic [7:0] byte_w;

  always_comb
  begin
    nxt_st = st_ff;
    nxt_st.clk_d = clk_now;
    nxt_st.dat_d = dat_now;
    nxt_st.rd_req = 1'b0;
    nxt_st.push = 1'b0;
    nxt_st.ovf = 1'b0;
    nxt_st.cap = {st_ff.cap[0], 1'b0};
    inst_w = st_ff.lsb ? {dat_now, st_ff.sh[15:1]}
                       : {st_ff.sh[14:0], dat_now};
    byte_w = scp_shin(st_ff.sh[7:0], dat_now, st_ff.lsb);
    // Read data comes back the cycle after the request
    if (st_ff.cap[1])
    begin
      nxt_st.tx = rd_data;
    end
    if (!st_ff.strap_done)
    begin
      // Straps settle through the synchroniser before being caught
      nxt_st.strap_wait = st_ff.strap_wait + 1'b1;
      if (st_ff.strap_wait == STRAP_WAIT_CYC)
      begin
        nxt_st.strap = pin_raw[5:3];
        nxt_st.i2c = |pin_raw[5:3];
        nxt_st.strap_done = 1'b1;
      end
    end
    else if (st_ff.i2c)
    begin
      // Device never drives the clock, only pulls data low
      nxt_st.sd_out = 1'b0;
      if (i2c_start)
      begin
        nxt_st.state = ST_I2C_RX;
        nxt_st.phase = PH_SLAVE;
        nxt_st.bits = '0;
        nxt_st.sd_oe = 1'b0;
      end
      else if (i2c_stop)
      begin
        nxt_st.state = ST_IDLE;
        nxt_st.sd_oe = 1'b0;
      end
      else
      begin
        unique case (st_ff.state)
          ST_I2C_RX:
          begin
            if (clk_rise && st_ff.bits != BYTE_DONE)
            begin
              nxt_st.sh = {st_ff.sh[14:0], dat_now};
              nxt_st.bits = st_ff.bits + 1'b1;
            end
            else if (clk_fall && st_ff.bits == BYTE_DONE)
            begin
              // Acknowledge goes out only after the clock has fallen
              nxt_st.state = ST_I2C_ACK;
              nxt_st.sd_oe = 1'b1;
              nxt_st.phase = (st_ff.phase == PH_DATA) ? PH_DATA
                             : st_ff.phase + 1'b1;
              unique case (st_ff.phase)
                PH_SLAVE:
                begin
                  if (st_ff.sh[7:1] != {I2C_ADDR_TOP, st_ff.strap})
                  begin
                    nxt_st.state = ST_I2C_IGN;
                    nxt_st.sd_oe = 1'b0;
                  end
                  else
                  begin
                    nxt_st.rd_dir = (st_ff.sh[0] == I2C_DIR_READ);
                    if (st_ff.sh[0] == I2C_DIR_READ)
                    begin
                      nxt_st.rd_req = 1'b1;
                      nxt_st.rd_addr = st_ff.ptr;
                      nxt_st.cap[0] = 1'b1;
                      nxt_st.ptr = st_ff.ptr + 1'b1;
                    end
                  end
                end
                PH_ADDR_HI:
                begin
                  nxt_st.addr_hi = st_ff.sh[7:0];
                end
                PH_ADDR_LO:
                begin
                  // Pointer is loaded even when no data follows
                  nxt_st.ptr = {st_ff.addr_hi, st_ff.sh[7:0]};
                end
                PH_DATA:
                begin
                  if (fifo_in_ready)
                  begin
                    nxt_st.push = 1'b1;
                    nxt_st.push_data = {st_ff.ptr, st_ff.sh[7:0]};
                    nxt_st.ptr = st_ff.ptr + 1'b1;
                  end
                  else
                  begin
                    // Full FIFO refuses the byte with a not-acknowledge
                    nxt_st.state = ST_I2C_IGN;
                    nxt_st.sd_oe = 1'b0;
                  end
                end
              endcase
            end
          end
          ST_I2C_ACK:
          begin
            if (clk_fall)
            begin
              nxt_st.bits = '0;
              if (st_ff.rd_dir)
              begin
                nxt_st.state = ST_I2C_TX;
                nxt_st.sd_oe = !st_ff.tx[7];
                nxt_st.tx = {st_ff.tx[6:0], 1'b0};
              end
              else
              begin
                nxt_st.state = ST_I2C_RX;
                nxt_st.sd_oe = 1'b0;
              end
            end
          end
          ST_I2C_TX:
          begin
            if (clk_rise)
            begin
              nxt_st.bits = st_ff.bits + 1'b1;
            end
            else if (clk_fall && st_ff.bits == BYTE_DONE)
            begin
              nxt_st.state = ST_I2C_MACK;
              nxt_st.mack_ok = 1'b0;
              nxt_st.sd_oe = 1'b0;
            end
            else if (clk_fall)
            begin
              nxt_st.sd_oe = !st_ff.tx[7];
              nxt_st.tx = {st_ff.tx[6:0], 1'b0};
            end
          end
          ST_I2C_MACK:
          begin
            if (clk_rise && dat_now)
            begin
              nxt_st.state = ST_IDLE;
            end
            else if (clk_rise)
            begin
              nxt_st.mack_ok = 1'b1;
              nxt_st.rd_req = 1'b1;
              nxt_st.rd_addr = st_ff.ptr;
              nxt_st.cap[0] = 1'b1;
              nxt_st.ptr = st_ff.ptr + 1'b1;
            end
            else if (clk_fall && st_ff.mack_ok)
            begin
              nxt_st.state = ST_I2C_TX;
              nxt_st.bits = '0;
              nxt_st.sd_oe = !st_ff.tx[7];
              nxt_st.tx = {st_ff.tx[6:0], 1'b0};
            end
          end
          default:
          begin
            nxt_st.sd_oe = 1'b0;
          end
        endcase
      end
    end
    else if (cs_n_now)
    begin
      // Chip select high ends any SPI transfer and drops a partial byte
      nxt_st.state = ST_IDLE;
      nxt_st.sd_oe = 1'b0;
      nxt_st.bits = '0;
    end
    else
    begin
      unique case (st_ff.state)
        ST_SPI_INST:
        begin
          if (clk_rise)
          begin
            nxt_st.sh = inst_w;
            nxt_st.bits = st_ff.bits + 1'b1;
            if (st_ff.bits == INST_LAST_BIT)
            begin
              nxt_st.bits = '0;
              nxt_st.rd_dir = inst_w[INST_RW_POS];
              nxt_st.left = inst_w[INST_CNT_POS+:2];
              nxt_st.stream = (inst_w[INST_CNT_POS+:2] == BC_STREAM);
              nxt_st.saddr = inst_w[REG_ADDR_TOP_BIT:0];
              nxt_st.state = inst_w[INST_RW_POS] ? ST_SPI_RD : ST_SPI_WR;
              if (inst_w[INST_RW_POS])
              begin
                nxt_st.rd_req = 1'b1;
                nxt_st.rd_addr = {3'h0, inst_w[REG_ADDR_TOP_BIT:0]};
                nxt_st.cap[0] = 1'b1;
              end
            end
          end
        end
        ST_SPI_WR:
        begin
          if (clk_rise)
          begin
            nxt_st.sh[7:0] = byte_w;
            nxt_st.bits = st_ff.bits + 1'b1;
            if (st_ff.bits == BYTE_LAST_BIT)
            begin
              nxt_st.bits = '0;
              // SPI cannot be stalled: a full FIFO loses the byte
              nxt_st.push = fifo_in_ready;
              nxt_st.ovf = !fifo_in_ready;
              nxt_st.push_data = {3'h0, st_ff.saddr, byte_w};
              nxt_st.saddr = scp_step(st_ff.saddr, st_ff.lsb);
              nxt_st.left = st_ff.left - 1'b1;
              if (!st_ff.stream && st_ff.left == '0)
              begin
                nxt_st.state = ST_SPI_DONE;
              end
            end
          end
        end
        ST_SPI_RD:
        begin
          if (clk_fall)
          begin
            nxt_st.sd_oe = 1'b1;
            nxt_st.sd_out = st_ff.lsb ? st_ff.tx[0] : st_ff.tx[7];
            nxt_st.tx = st_ff.lsb ? {1'b0, st_ff.tx[7:1]}
                                  : {st_ff.tx[6:0], 1'b0};
          end
          else if (clk_rise)
          begin
            nxt_st.bits = st_ff.bits + 1'b1;
            if (st_ff.bits == BYTE_LAST_BIT)
            begin
              nxt_st.bits = '0;
              nxt_st.saddr = scp_step(st_ff.saddr, st_ff.lsb);
              nxt_st.left = st_ff.left - 1'b1;
              nxt_st.rd_req = 1'b1;
              nxt_st.rd_addr = {3'h0, scp_step(st_ff.saddr, st_ff.lsb)};
              nxt_st.cap[0] = 1'b1;
              if (!st_ff.stream && st_ff.left == '0)
              begin
                nxt_st.state = ST_SPI_DONE;
              end
            end
          end
        end
        ST_SPI_DONE:
        begin
          if (clk_fall)
          begin
            nxt_st.sd_oe = 1'b0;
          end
        end
        default:
        begin
          // Bit order is fixed for the whole transfer at select
          nxt_st.state = ST_SPI_INST;
          nxt_st.lsb = lsb_first;
          nxt_st.bits = '0;
          nxt_st.sd_oe = 1'b0;
        end
      endcase
    end
  end

  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      st_ff <= '{state: ST_IDLE, clk_d: 1'b1, dat_d: 1'b1,
                 ptr: PTR_RST, default: '0};
    end
    else
    begin
      st_ff <= nxt_st;
    end
  end

  // ****************************************
  // Outputs
  // ****************************************
  assign ser_data_out = st_ff.sd_out;
  assign ser_data_oe = st_ff.sd_oe;
  assign i2c_mode = st_ff.i2c;
  assign spi_wr_ovf = st_ff.ovf;
  assign rd_req = st_ff.rd_req;
  assign rd_addr = st_ff.rd_addr;
  assign wr_addr = fifo_out[ENTRY_W-1:DATA_W];
  assign wr_data = fifo_out[DATA_W-1:0];

endmodule : scp_slave
